//--- rtl/cfg_mgmt_user.sv
`timescale 1ns/100ps
module cfg_mgmt_user
	import cfg_mgmt_pkg::*;
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	cfg_mgmt_if.user         mgmt
);

	user_state_e st_reg;
	logic [9:0]  addr_reg;
	logic [31:0] wdata_reg;
	logic [3:0]  be_reg;
	logic        rd_en_reg;
	logic        wr_en_reg;
	logic        ovr_reg;
	logic        pend_reg;
	logic        op_rd_reg;
	logic        done_reg;
	logic [31:0] rdata_reg;
	logic [63:0] dsn_reg;
	logic [31:0] prdata_reg;
	logic        pready_reg;
	logic        pslverr_reg;

	logic        apb_wr;
	logic        apb_prep;
	logic        idle;
	logic        wr_ctrl;
	logic        start_wr;
	logic        start_rd;
	logic        mapped;
	logic [31:0] apb_word;

	// second access cycle completes; data and error prepared one cycle earlier
	assign apb_prep = psel & penable & ~pready_reg;
	assign apb_wr   = psel & penable & pready_reg & pwrite;
	assign idle     = (st_reg == ST_IDLE);
	assign wr_ctrl  = apb_wr && paddr == UR_CTRL;
	assign start_wr = wr_ctrl & pwdata[CTL_WR_BIT] & idle;
	assign start_rd = wr_ctrl & pwdata[CTL_RD_BIT] & ~pwdata[CTL_WR_BIT] & idle;

	assign mapped = paddr[7:6] == 2'b00 && paddr[1:0] == 2'b00 && paddr <= UR_MIR3;
	assign apb_word =
		(paddr == UR_CTRL)   ? {28'h0, pend_reg, ovr_reg, 2'b00} :
		(paddr == UR_ADDR)   ? {22'h0, addr_reg} :
		(paddr == UR_WDATA)  ? wdata_reg :
		(paddr == UR_BYTEEN) ? {28'h0, be_reg} :
		(paddr == UR_RDATA)  ? rdata_reg :
		(paddr == UR_STATUS) ? {30'h0, done_reg, ~idle} :
		(paddr == UR_DSN_LO) ? dsn_reg[31:0] :
		(paddr == UR_DSN_HI) ? dsn_reg[63:32] :
		(paddr == UR_MIR0)   ? {mgmt.status_mirror, mgmt.command_mirror} :
		(paddr == UR_MIR1)   ? {mgmt.dev_status_mirror, mgmt.dev_control_mirror} :
		(paddr == UR_MIR2)   ? {mgmt.link_status_mirror, mgmt.link_control_mirror} :
		(paddr == UR_MIR3)   ? {10'h0, mgmt.ecrc_check_en, mgmt.ecrc_gen_en, 1'b0, mgmt.link_state,
		                        mgmt.dev_control2_mirror} :
		32'h0000_0000;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_reg  <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else begin
			pready_reg  <= apb_prep;
			prdata_reg  <= apb_prep ? apb_word : 32'h0000_0000;
			pslverr_reg <= apb_prep & ~mapped;
		end
	end

	// request fields frozen while an access is outstanding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_reg  <= 10'h000;
			wdata_reg <= 32'h0000_0000;
			be_reg    <= 4'h0;
			ovr_reg   <= 1'b0;
			pend_reg  <= 1'b0;
			dsn_reg   <= 64'h0000_0000_0000_0000;
		end else if (apb_wr && idle) begin
			if (paddr == UR_ADDR)   addr_reg  <= pwdata[9:0];
			if (paddr == UR_WDATA)  wdata_reg <= pwdata;
			if (paddr == UR_BYTEEN) be_reg    <= pwdata[3:0];
			if (paddr == UR_DSN_LO) dsn_reg[31:0]  <= pwdata;
			if (paddr == UR_DSN_HI) dsn_reg[63:32] <= pwdata;
			if (paddr == UR_CTRL) begin
				ovr_reg  <= pwdata[CTL_OVR_BIT];
				pend_reg <= pwdata[CTL_PEND_BIT];
			end
		end else if (wr_ctrl) begin
			// pending flag must stay writable during an access
			pend_reg <= pwdata[CTL_PEND_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_reg    <= ST_IDLE;
			rd_en_reg <= 1'b0;
			wr_en_reg <= 1'b0;
			op_rd_reg <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			rd_en_reg <= start_rd;
			wr_en_reg <= start_wr;
			unique case (st_reg)
				ST_IDLE: begin
					if (start_rd | start_wr) begin
						st_reg    <= ST_WAIT;
						op_rd_reg <= start_rd;
					end
				end
				ST_WAIT: begin
					if (mgmt.mgmt_done) begin
						st_reg <= ST_IDLE;
						if (op_rd_reg) rdata_reg <= mgmt.mgmt_read_data;
					end
				end
			endcase
		end
	end

	// sticky done; a completion in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg <= 1'b0;
		end else if (st_reg == ST_WAIT && mgmt.mgmt_done) begin
			done_reg <= 1'b1;
		end else if (apb_wr && paddr == UR_STATUS && pwdata[STAT_DONE_BIT]) begin
			done_reg <= 1'b0;
		end
	end

	assign prdata                = prdata_reg;
	assign pready                = pready_reg;
	assign pslverr               = pslverr_reg;
	assign mgmt.mgmt_addr        = addr_reg;
	assign mgmt.mgmt_write_data  = wdata_reg;
	assign mgmt.mgmt_byte_en     = be_reg;
	assign mgmt.mgmt_rd_en       = rd_en_reg;
	assign mgmt.mgmt_wr_en       = wr_en_reg;
	assign mgmt.mgmt_wr_readonly = ovr_reg;
	assign mgmt.trn_pending      = pend_reg;
	assign mgmt.serial_number    = dsn_reg;

endmodule

//--- rtl/cfg_space_dev.sv
// Implementation choices: the register offsets and register access over APB.
`timescale 1ns/100ps
module cfg_space_dev
	import cfg_mgmt_pkg::*;
#(
	parameter logic [15:0] VENDOR_ID  = 16'h1AB0, // arbitrary value
	parameter logic [15:0] DEVICE_ID  = 16'h0C01, // arbitrary value
	parameter logic [7:0]  REVISION   = 8'h01,    // arbitrary value
	parameter logic [23:0] CLASS_CODE = 24'h058000
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	cfg_mgmt_if.device       mgmt,
	input  wire logic [2:0]  link_state_in,
	input  wire logic [15:0] link_status_in,
	input  wire logic [3:0]  dev_error_in
);

	logic [15:0] cmd_reg;
	logic [15:0] cmd_next;
	logic [15:0] dctl_reg;
	logic [15:0] dctl_next;
	logic [15:0] dct2_reg;
	logic [15:0] dct2_next;
	logic [15:0] lctl_reg;
	logic [15:0] lctl_next;
	logic [31:0] aer_reg;
	logic [31:0] aer_next;
	logic [15:0] dstat_reg;
	logic [15:0] dstat_next;
	logic [15:0] lstat_reg;
	logic [2:0]  lstate_reg;
	logic [31:0] rdata_reg;
	logic        done_reg;

	logic        take_rd;
	logic        take_wr;
	logic        ovr;
	logic [31:0] wd;
	logic [3:0]  be;
	logic [31:0] rd_word;
	logic [31:0] cmd_word;
	logic [31:0] dctl_word;
	logic [31:0] dct2_word;
	logic [31:0] lctl_word;
	logic [31:0] aer_word;
	logic        hit_id;
	logic        hit_cmd;
	logic        hit_class;
	logic        hit_cap_ptr;
	logic        hit_pcie_cap;
	logic        hit_dctl;
	logic        hit_lctl;
	logic        hit_dct2;
	logic        hit_aer_hdr;
	logic        hit_aer;
	logic        hit_dsn_hdr;
	logic        hit_dsn_lo;
	logic        hit_dsn_hi;

	// merge write data into old value lane by lane, only where mask allows
	function automatic logic [31:0] merge(
		input logic [31:0] old_v,
		input logic [31:0] new_v,
		input logic [3:0]  lane_en,
		input logic [31:0] mask
	);
		logic [31:0] lane;
		for (int i = 0; i < 4; i++) begin
			lane[8*i +: 8] = {8{lane_en[i]}};
		end
		return (old_v & ~(lane & mask)) | (new_v & lane & mask);
	endfunction

	function automatic logic [31:0] wmask(
		input logic [31:0] rw,
		input logic [31:0] ro,
		input logic        en_ro
	);
		return rw | (en_ro ? ro : 32'h0000_0000);
	endfunction

	// one access per done; a request seen while done is high is a repeat
	assign take_wr = mgmt.mgmt_wr_en & ~done_reg;
	assign take_rd = mgmt.mgmt_rd_en & ~mgmt.mgmt_wr_en & ~done_reg;
	assign ovr     = mgmt.mgmt_wr_readonly;
	assign wd      = mgmt.mgmt_write_data;
	assign be      = mgmt.mgmt_byte_en;

	// status halves and attribute bits are outside every mask
	assign cmd_word  = merge({16'h0000, cmd_reg}, wd, be, wmask(CMD_RW_MASK, CMD_RO_MASK, ovr));
	assign dctl_word = merge({16'h0000, dctl_reg}, wd, be, wmask(DCTL_RW_MASK, DCTL_RO_MASK, ovr));
	assign dct2_word = merge({16'h0000, dct2_reg}, wd, be, wmask(DCT2_RW_MASK, DCT2_RO_MASK, ovr));
	assign lctl_word = merge({16'h0000, lctl_reg}, wd, be, wmask(LCTL_RW_MASK, LCTL_RO_MASK, ovr));
	assign aer_word  = merge(aer_reg, wd, be, wmask(AER_RW_MASK, AER_RO_MASK, ovr));

	assign cmd_next  = (take_wr && mgmt.mgmt_addr == DW_CMD_STAT) ? cmd_word[15:0] : cmd_reg;
	assign dctl_next = (take_wr && mgmt.mgmt_addr == DW_DEV_CTL) ? dctl_word[15:0] : dctl_reg;
	assign dct2_next = (take_wr && mgmt.mgmt_addr == DW_DEV_CTL2) ? dct2_word[15:0] : dct2_reg;
	assign lctl_next = (take_wr && mgmt.mgmt_addr == DW_LNK_CTL) ? lctl_word[15:0] : lctl_reg;
	assign aer_next  = (take_wr && mgmt.mgmt_addr == DW_AER_CTL) ? aer_word : aer_reg;

	assign dstat_next = (16'(mgmt.trn_pending) << TRN_PEND_BIT) | {12'h000, dev_error_in};

	// one hit per implemented dword; any other index reads as zero
	assign hit_id       = mgmt.mgmt_addr == DW_ID;
	assign hit_cmd      = mgmt.mgmt_addr == DW_CMD_STAT;
	assign hit_class    = mgmt.mgmt_addr == DW_CLASS;
	assign hit_cap_ptr  = mgmt.mgmt_addr == DW_CAP_PTR;
	assign hit_pcie_cap = mgmt.mgmt_addr == DW_PCIE_CAP;
	assign hit_dctl     = mgmt.mgmt_addr == DW_DEV_CTL;
	assign hit_lctl     = mgmt.mgmt_addr == DW_LNK_CTL;
	assign hit_dct2     = mgmt.mgmt_addr == DW_DEV_CTL2;
	assign hit_aer_hdr  = mgmt.mgmt_addr == DW_AER_HDR;
	assign hit_aer      = mgmt.mgmt_addr == DW_AER_CTL;
	assign hit_dsn_hdr  = mgmt.mgmt_addr == DW_DSN_HDR;
	assign hit_dsn_lo   = mgmt.mgmt_addr == DW_DSN_LO;
	assign hit_dsn_hi   = mgmt.mgmt_addr == DW_DSN_HI;

	// and-or select: every source is an operand, so a register change
	// reaches the read path even when the address stays the same
	assign rd_word =
		({32{hit_id}}       & {DEVICE_ID, VENDOR_ID}) |
		({32{hit_cmd}}      & {STAT_MIRROR_VAL, cmd_reg}) |
		({32{hit_class}}    & {CLASS_CODE, REVISION}) |
		({32{hit_cap_ptr}}  & CAP_PTR_WORD) |
		({32{hit_pcie_cap}} & PCIE_CAP_WORD) |
		({32{hit_dctl}}     & {dstat_reg, dctl_reg}) |
		({32{hit_lctl}}     & {lstat_reg, lctl_reg}) |
		({32{hit_dct2}}     & {16'h0000, dct2_reg}) |
		({32{hit_aer_hdr}}  & AER_HDR_WORD) |
		({32{hit_aer}}      & (aer_reg | AER_CAP_BITS)) |
		({32{hit_dsn_hdr}}  & DSN_HDR_WORD) |
		({32{hit_dsn_lo}}   & mgmt.serial_number[31:0]) |
		({32{hit_dsn_hi}}   & mgmt.serial_number[63:32]);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_reg  <= CMD_RST;
			dctl_reg <= DCTL_RST;
			dct2_reg <= DCT2_RST;
			lctl_reg <= LCTL_RST;
			aer_reg  <= AER_RST;
		end else begin
			cmd_reg  <= cmd_next;
			dctl_reg <= dctl_next;
			dct2_reg <= dct2_next;
			lctl_reg <= lctl_next;
			aer_reg  <= aer_next;
		end
	end

	// live status sampled every cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dstat_reg  <= 16'h0000;
			lstat_reg  <= 16'h0000;
			lstate_reg <= LS_L0;
		end else begin
			dstat_reg  <= dstat_next;
			lstat_reg  <= link_status_in;
			lstate_reg <= link_state_in;
		end
	end

	// done one cycle after the request; read data held until the next read
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_reg  <= 1'b0;
			rdata_reg <= 32'h0000_0000;
		end else begin
			done_reg <= take_rd | take_wr;
			if (take_rd) begin
				rdata_reg <= rd_word;
			end
		end
	end

	assign mgmt.mgmt_read_data      = rdata_reg;
	assign mgmt.mgmt_done           = done_reg;
	// unsupported mirror, kept at a fixed value
	assign mgmt.status_mirror       = STAT_MIRROR_VAL;
	assign mgmt.command_mirror      = cmd_reg;
	assign mgmt.dev_status_mirror   = dstat_reg;
	assign mgmt.dev_control_mirror  = dctl_reg;
	assign mgmt.dev_control2_mirror = dct2_reg;
	assign mgmt.link_status_mirror  = lstat_reg;
	assign mgmt.link_control_mirror = lctl_reg;
	assign mgmt.ecrc_gen_en         = aer_reg[ECRC_GEN_BIT];
	assign mgmt.ecrc_check_en       = aer_reg[ECRC_CHK_BIT];
	assign mgmt.link_state          = lstate_reg;

endmodule

//--- shared/cfg_mgmt_if.sv
`timescale 1ns/100ps
interface cfg_mgmt_if;
	logic [9:0]  mgmt_addr;
	logic [31:0] mgmt_write_data;
	logic [3:0]  mgmt_byte_en;
	logic        mgmt_wr_en;
	logic        mgmt_rd_en;
	logic        mgmt_wr_readonly;
	logic [31:0] mgmt_read_data;
	logic        mgmt_done;
	logic [15:0] status_mirror;
	logic [15:0] command_mirror;
	logic [15:0] dev_status_mirror;
	logic [15:0] dev_control_mirror;
	logic [15:0] dev_control2_mirror;
	logic [15:0] link_status_mirror;
	logic [15:0] link_control_mirror;
	logic        ecrc_gen_en;
	logic        ecrc_check_en;
	logic [2:0]  link_state;
	logic        trn_pending;
	logic [63:0] serial_number;

	modport device (
		input  mgmt_addr, mgmt_write_data, mgmt_byte_en, mgmt_wr_en, mgmt_rd_en,
		input  mgmt_wr_readonly, trn_pending, serial_number,
		output mgmt_read_data, mgmt_done, status_mirror, command_mirror, dev_status_mirror,
		output dev_control_mirror, dev_control2_mirror, link_status_mirror, link_control_mirror,
		output ecrc_gen_en, ecrc_check_en, link_state
	);

	modport user (
		output mgmt_addr, mgmt_write_data, mgmt_byte_en, mgmt_wr_en, mgmt_rd_en,
		output mgmt_wr_readonly, trn_pending, serial_number,
		input  mgmt_read_data, mgmt_done, status_mirror, command_mirror, dev_status_mirror,
		input  dev_control_mirror, dev_control2_mirror, link_status_mirror, link_control_mirror,
		input  ecrc_gen_en, ecrc_check_en, link_state
	);
endinterface

//--- shared/cfg_mgmt_pkg.sv
package cfg_mgmt_pkg;

	localparam int ADDR_W = 10;
	localparam int DATA_W = 32;
	localparam int BE_W   = 4;

	// configuration space dword indices
	localparam logic [9:0] DW_ID        = 10'h000;
	localparam logic [9:0] DW_CMD_STAT  = 10'h001;
	localparam logic [9:0] DW_CLASS     = 10'h002;
	localparam logic [9:0] DW_CAP_PTR   = 10'h00D;
	localparam logic [9:0] DW_PCIE_CAP  = 10'h018;
	localparam logic [9:0] DW_DEV_CTL   = 10'h01A;
	localparam logic [9:0] DW_LNK_CTL   = 10'h01C;
	localparam logic [9:0] DW_DEV_CTL2  = 10'h022;
	localparam logic [9:0] DW_AER_HDR   = 10'h040;
	localparam logic [9:0] DW_AER_CTL   = 10'h046;
	localparam logic [9:0] DW_DSN_HDR   = 10'h050;
	localparam logic [9:0] DW_DSN_LO    = 10'h051;
	localparam logic [9:0] DW_DSN_HI    = 10'h052;

	// fixed structure words
	localparam logic [31:0] CAP_PTR_WORD  = 32'h0000_0060;
	localparam logic [31:0] PCIE_CAP_WORD = 32'h0002_0010;
	localparam logic [31:0] AER_HDR_WORD  = 32'h1401_0001;
	localparam logic [31:0] DSN_HDR_WORD  = 32'h0001_0003;
	localparam logic [31:0] AER_CAP_BITS  = 32'h0000_00A0;

	// writable bits, and read-only bits the override may write
	localparam logic [31:0] CMD_RW_MASK  = 32'h0000_0546;
	localparam logic [31:0] CMD_RO_MASK  = 32'h0000_0009;
	localparam logic [31:0] DCTL_RW_MASK = 32'h0000_7FFF;
	localparam logic [31:0] DCTL_RO_MASK = 32'h0000_0000;
	localparam logic [31:0] DCT2_RW_MASK = 32'h0000_001F;
	localparam logic [31:0] DCT2_RO_MASK = 32'h0000_0000;
	localparam logic [31:0] LCTL_RW_MASK = 32'h0000_01C3;
	localparam logic [31:0] LCTL_RO_MASK = 32'h0000_0028;
	localparam logic [31:0] AER_RW_MASK  = 32'h0000_0140;
	localparam logic [31:0] AER_RO_MASK  = 32'h0000_0000;

	// values after reset
	localparam logic [15:0] CMD_RST   = 16'h0000;
	localparam logic [15:0] DCTL_RST  = 16'h2810;
	localparam logic [15:0] DCT2_RST  = 16'h0000;
	localparam logic [15:0] LCTL_RST  = 16'h0000;
	localparam logic [31:0] AER_RST   = 32'h0000_0000;
	localparam logic [15:0] STAT_MIRROR_VAL = 16'h0000;

	localparam int TRN_PEND_BIT = 5;
	localparam int ECRC_GEN_BIT = 6;
	localparam int ECRC_CHK_BIT = 8;

	typedef enum logic [2:0] {
		LS_L0       = 3'b000,
		LS_L1       = 3'b001,
		LS_L23_RDY  = 3'b010,
		LS_PME      = 3'b011,
		LS_L0S      = 3'b100,
		LS_TO_L1    = 3'b101,
		LS_TO_L23   = 3'b110,
		LS_RESERVED = 3'b111
	} link_state_e;

	// apb register map of the user end (byte addresses)
	localparam int PADDR_W = 8;
	localparam logic [7:0] UR_CTRL   = 8'h00;
	localparam logic [7:0] UR_ADDR   = 8'h04;
	localparam logic [7:0] UR_WDATA  = 8'h08;
	localparam logic [7:0] UR_BYTEEN = 8'h0C;
	localparam logic [7:0] UR_RDATA  = 8'h10;
	localparam logic [7:0] UR_STATUS = 8'h14;
	localparam logic [7:0] UR_DSN_LO = 8'h18;
	localparam logic [7:0] UR_DSN_HI = 8'h1C;
	localparam logic [7:0] UR_MIR0   = 8'h20;
	localparam logic [7:0] UR_MIR1   = 8'h24;
	localparam logic [7:0] UR_MIR2   = 8'h28;
	localparam logic [7:0] UR_MIR3   = 8'h2C;

	localparam int CTL_RD_BIT   = 0;
	localparam int CTL_WR_BIT   = 1;
	localparam int CTL_OVR_BIT  = 2;
	localparam int CTL_PEND_BIT = 3;
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_DONE_BIT = 1;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b01,
		ST_WAIT = 2'b10
	} user_state_e;

endpackage

//--- sim/cfg_mgmt_asserts.sv
`timescale 1ns/100ps
module cfg_mgmt_asserts
	import cfg_mgmt_pkg::*;
(
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic [9:0]  mgmt_addr,
	input wire logic        mgmt_wr_en,
	input wire logic        mgmt_rd_en,
	input wire logic [31:0] mgmt_read_data,
	input wire logic        mgmt_done,
	input wire logic [15:0] status_mirror,
	input wire logic [15:0] command_mirror,
	input wire logic [15:0] dev_status_mirror,
	input wire logic        ecrc_gen_en,
	input wire logic        ecrc_check_en,
	input wire logic        trn_pending,
	input wire logic [63:0] serial_number
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// a request raised while done is still high is not taken
	wire take    = (mgmt_rd_en | mgmt_wr_en) & !mgmt_done;
	wire rd_take = mgmt_rd_en & !mgmt_wr_en & !mgmt_done;

	a_done_follows: assert property (take |=> mgmt_done)
		else $error("no done after request");
	a_done_pulse: assert property (mgmt_done |=> !mgmt_done)
		else $error("done longer than one cycle");
	a_no_stray_done: assert property (!take |=> !mgmt_done)
		else $error("done without request");
	a_rdata_held: assert property (!rd_take |=> $stable(mgmt_read_data))
		else $error("read data moved without read");
	a_cmd_read: assert property (rd_take && mgmt_addr == DW_CMD_STAT |=>
		mgmt_read_data[15:0] == command_mirror)
		else $error("command read differs from mirror");
	a_dsn_read: assert property (rd_take && mgmt_addr == DW_DSN_HI |=>
		mgmt_read_data == serial_number[63:32])
		else $error("serial upper word wrong");
	a_ecrc_bits: assert property (rd_take && mgmt_addr == DW_AER_CTL |=>
		mgmt_read_data[ECRC_GEN_BIT] == ecrc_gen_en && mgmt_read_data[ECRC_CHK_BIT] == ecrc_check_en)
		else $error("ecrc outputs differ from register");
	a_pend_bit: assert property (dev_status_mirror[TRN_PEND_BIT] == $past(trn_pending))
		else $error("pending bit not following input");
	a_status_fixed: assert property (status_mirror == STAT_MIRROR_VAL)
		else $error("status mirror not fixed");
	a_addr_held: assert property (take |=> $stable(mgmt_addr))
		else $error("address moved during access");
	a_unmapped_zero: assert property (rd_take && mgmt_addr > DW_DSN_HI |=>
		mgmt_read_data == 32'h0000_0000)
		else $error("unimplemented dword not zero");
endmodule

//--- sim/testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("[ERR] %0t got %h exp %h", $time, (a), (b)); end end
module testbench
	import cfg_mgmt_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [2:0]  link_state_in = 3'h0;
	logic [15:0] link_status_in = 16'h0000;
	logic [3:0]  dev_error_in = 4'h0;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [31:0] q;
	logic        err;
	logic [1:0]  lvl = 2'b00;
	int          n_fail = 0;
	int          n_checks = 0;

	always #25 pclk = ~pclk;

	cfg_mgmt_if mgmt ();
	cfg_space_dev i_cfg_space_dev (.pclk(pclk), .presetn(presetn), .mgmt(mgmt), .link_state_in(link_state_in),
		.link_status_in(link_status_in), .dev_error_in(dev_error_in));
	cfg_mgmt_user i_cfg_mgmt_user (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .mgmt(mgmt));
	cfg_mgmt_asserts i_cfg_mgmt_asserts (.pclk(pclk), .presetn(presetn), .mgmt_addr(mgmt.mgmt_addr),
		.mgmt_wr_en(mgmt.mgmt_wr_en), .mgmt_rd_en(mgmt.mgmt_rd_en), .mgmt_read_data(mgmt.mgmt_read_data),
		.mgmt_done(mgmt.mgmt_done), .status_mirror(mgmt.status_mirror), .command_mirror(mgmt.command_mirror),
		.dev_status_mirror(mgmt.dev_status_mirror), .ecrc_gen_en(mgmt.ecrc_gen_en),
		.ecrc_check_en(mgmt.ecrc_check_en), .trn_pending(mgmt.trn_pending), .serial_number(mgmt.serial_number));

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		`CHK(pready, 1'b1)
	endtask

	// lvl carries the override and pending levels into every start
	task automatic cfg(input logic [1:0] op, input logic [9:0] a, input logic [31:0] d, input logic [3:0] be);
		int n;
		n = 0;
		apb(1'b1, UR_ADDR, {22'h0, a});
		apb(1'b1, UR_WDATA, d);
		apb(1'b1, UR_BYTEEN, {28'h0, be});
		apb(1'b1, UR_CTRL, {28'h0, lvl, op});
		do begin
			apb(1'b0, UR_STATUS, 32'h0);
			n++;
		end while (q[STAT_DONE_BIT] !== 1'b1 && n < 10);
		`CHK(q[1:0], 2'b10)
		apb(1'b1, UR_STATUS, 32'h0000_0002);
		apb(1'b0, UR_RDATA, 32'h0);
	endtask

	task t_reset;
		apb(1'b0, UR_MIR1, 32'h0);
		`CHK(q[15:0], DCTL_RST)
		apb(1'b0, UR_MIR0, 32'h0);
		`CHK({err, q}, {1'b0, 32'h0000_0000})
		apb(1'b0, 8'h30, 32'h0);
		`CHK({err, q}, {1'b1, 32'h0000_0000})
	endtask

	task t_bytes;
		cfg(2'b10, DW_CMD_STAT, 32'hFFFF_FFFF, 4'b0001);
		cfg(2'b01, DW_CMD_STAT, 32'h0, 4'h0);
		`CHK(q, 32'h0000_0046)
		cfg(2'b10, DW_CMD_STAT, 32'hFFFF_FFFF, 4'b0010);
		cfg(2'b01, DW_CMD_STAT, 32'h0, 4'h0);
		`CHK(q, 32'h0000_0546)
		cfg(2'b10, DW_CMD_STAT, 32'h0, 4'b1100);
		apb(1'b0, UR_MIR0, 32'h0);
		`CHK(q, 32'h0000_0546)
		cfg(2'b01, DW_PCIE_CAP, 32'h0, 4'h0);
		`CHK(q, PCIE_CAP_WORD)
		cfg(2'b01, 10'h3FF, 32'h0, 4'h0);
		`CHK(q, 32'h0000_0000)
	endtask

	task t_override;
		lvl = 2'b01;
		cfg(2'b10, DW_CMD_STAT, 32'hFFFF_FFFF, 4'hF);
		cfg(2'b10, DW_LNK_CTL, 32'hFFFF_FFFF, 4'hF);
		lvl = 2'b00;
		cfg(2'b01, DW_CMD_STAT, 32'h0, 4'h0);
		`CHK(q, 32'h0000_054F)
		cfg(2'b10, DW_CMD_STAT, 32'h0, 4'hF);
		apb(1'b0, UR_MIR0, 32'h0);
		`CHK(q, 32'h0000_0009)
		apb(1'b0, UR_MIR2, 32'h0);
		`CHK(q, 32'h0000_01EB)
	endtask

	task t_ecrc;
		cfg(2'b10, DW_AER_CTL, 32'hFFFF_FFFF, 4'hF);
		apb(1'b0, UR_MIR3, 32'h0);
		`CHK(q[21:19], 3'b110)
		cfg(2'b01, DW_AER_CTL, 32'h0, 4'h0);
		`CHK(q, 32'h0000_01E0)
		cfg(2'b10, DW_AER_CTL, 32'h0000_0040, 4'hF);
		apb(1'b0, UR_MIR3, 32'h0);
		`CHK(q[21:19], 3'b010)
		cfg(2'b10, DW_DEV_CTL2, 32'hFFFF_FFFF, 4'hF);
		apb(1'b0, UR_MIR3, 32'h0);
		`CHK(q[15:0], 16'h001F)
	endtask

	task t_mirrors;
		link_status_in <= 16'hA5C3;
		dev_error_in <= 4'hA;
		lvl = 2'b10;
		cfg(2'b10, DW_DEV_CTL, 32'hFFFF_FFFF, 4'hF);
		cfg(2'b01, DW_DEV_CTL, 32'h0, 4'h0);
		`CHK(q, 32'h002A_7FFF)
		lvl = 2'b00;
		apb(1'b1, UR_CTRL, 32'h0);
		apb(1'b0, UR_MIR1, 32'h0);
		`CHK(q[31:16], 16'h000A)
		cfg(2'b10, DW_LNK_CTL, 32'h0, 4'hF);
		apb(1'b0, UR_MIR2, 32'h0);
		`CHK(q, 32'hA5C3_0028)
		for (int i = 0; i < 8; i++) begin
			link_state_in <= i[2:0];
			apb(1'b0, UR_MIR3, 32'h0);
			`CHK(q[18:16], i[2:0])
		end
	endtask

	task t_dsn;
		apb(1'b1, UR_DSN_LO, 32'h89AB_CDEF);
		apb(1'b1, UR_DSN_HI, 32'h0123_4567);
		cfg(2'b01, DW_DSN_LO, 32'h0, 4'h0);
		`CHK(q, 32'h89AB_CDEF)
		cfg(2'b01, DW_DSN_HI, 32'h0, 4'h0);
		`CHK(q, 32'h0123_4567)
	endtask

	task complete_run;
		$display("checks %0d errors %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	initial begin
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_bytes();
		t_override();
		t_ecrc();
		t_mirrors();
		t_dsn();
		complete_run();
	end

	// far beyond the fewer than one thousand cycles the scenarios need
	initial begin
		#2000000;
		n_fail++;
		complete_run();
	end
endmodule
